// file: verilog/pllc_pkg.sv
package pllc_pkg;
    // register word indices; byte address is four times the index
    localparam logic [5:0] IDX_CTL = 6'h36;
    localparam logic [5:0] IDX_BWC = 6'h37;
    localparam logic [5:0] IDX_MUL_LO = 6'h38;
    localparam logic [5:0] IDX_MUL_HI = 6'h39;
    localparam logic [5:0] IDX_RANGE = 6'h3A;

    // loop control register fields
    localparam int CTL_IE = 7;
    localparam int CTL_FLAG = 6;
    localparam int CTL_ON = 5;
    localparam int CTL_BASE_SEL = 4;
    localparam int CTL_VPR_HI = 1;
    localparam int CTL_VPR_LO = 0;

    // bandwidth control register fields
    localparam int BWC_AUTO = 7;
    localparam int BWC_LOCK = 6;
    localparam int BWC_ACQ = 5;

    localparam int DATA_W = 8;
    localparam int MUL_HI_W = 4;
    localparam int MUL_W = 12;

    localparam logic [3:0] MUL_HI_RST = 4'h0;
    localparam logic [7:0] MUL_LO_RST = 8'h40;
    localparam logic [7:0] RANGE_RST = 8'h40;
    localparam logic [1:0] VPR_RST = 2'h0;
    localparam logic LOOP_ON_RST = 1'b1;

    localparam logic [11:0] MUL_ZERO = 12'h000;
    localparam logic [11:0] MUL_ONE = 12'h001;
    localparam logic [7:0] RANGE_ZERO = 8'h00;
    localparam logic [23:0] UPPER_ZERO = 24'h000000;
endpackage

// file: verilog/pllc_sync.sv
`timescale 1ns/100ps
module pllc_sync
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            stage <= 3'h0;
        else
            stage <= {stage[1:0], async_in};
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sync_out <= 1'b0;
        else if (stage[2] == stage[1])
            sync_out <= stage[2];
    end
endmodule

// file: verilog/pllc_lock_flag.sv
`timescale 1ns/100ps
module pllc_lock_flag
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic lock_sync,
    input wire logic auto_mode,
    input wire logic clear,
    output logic flag
);
    logic lock_q;
    logic lock_edge;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            lock_q <= 1'b0;
        else
            lock_q <= lock_sync;
    end

    assign lock_edge = lock_sync ^ lock_q; // R21

    // a lock change in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            flag <= 1'b0;
        else if (!auto_mode)
            flag <= 1'b0; // R11
        else if (lock_edge)
            flag <= 1'b1; // R10
        else if (clear)
            flag <= 1'b0;
    end
endmodule

// file: verilog/pllc_ctrl.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
// Summary of operation
// R1 - multiplier from twelve bits, zero acts as one
// R2 - multiplier resets to sixty-four
// R3 - multiplier writes ignored while loop enabled
// R4 - upper high-register bits read zero
// R5 - range writes ignored while loop enabled
// R6 - zero range disables loop, clears base select
// R7 - base select cannot set with zero range
// R8 - range register resets to 0x40
// R9 - lock change requests interrupt when enabled
// R10 - flag sets on lock change in auto
// R11 - manual bandwidth: no interrupt, flag zero
// R12 - software reads lock after interrupt
// R13 - base select allowed while unlocked; software checks
// R14 - wait mode leaves generator untouched
// R15 - stop without osc option: everything off, low
// R16 - stop with osc option: loop off only
// R17 - break protection keeps flag on access
// R18 - flag cleared in break stays cleared
// R19 - software programs range before enabling loop
// R20 - control register read clears flag
// R21 - synchronised lock edge sets flag
module pllc_ctrl
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic lock_in,
    input wire logic acq_in,
    input wire logic stop_mode,
    input wire logic osc_run_in_stop,
    input wire logic break_state,
    input wire logic break_flag_clear_enable,
    output logic loop_power,
    output logic base_clock_select,
    output logic [11:0] multiplier_n,
    output logic [7:0] range_linear,
    output logic [1:0] power_range,
    output logic auto_bandwidth,
    output logic acq_manual,
    output logic osc_enable,
    output logic clock_out_enable,
    output logic clockgen_irq_out
);
    logic req;
    logic take;
    logic [5:0] word_idx;
    logic [7:0] wr_byte;
    logic lane_ok;
    logic wr_ctl;
    logic wr_bwc;
    logic wr_mul_lo;
    logic wr_mul_hi;
    logic wr_range;
    logic rd_ctl;
    logic [7:0] rd_byte;
    logic flag_seen;
    logic flag_protect;
    logic flag_clear;
    logic [3:0] mul_hi;
    logic [7:0] mul_lo;
    logic [11:0] mul_all;
    logic [1:0] vpr;
    logic loop_enable;
    logic base_sel;
    logic irq_en;
    logic auto_mode;
    logic acq_store;
    logic lock_sync;
    logic acq_sync;
    logic flag;
    logic range_zero;
    logic stop_full;
    logic next_loop_power;
    logic next_osc_enable;
    logic next_clock_out_enable;
    logic next_irq;
    logic [11:0] next_multiplier_n;

    // bus decode; the data byte lives in lane 0 only
    assign req = wb_cyc_i & wb_stb_i;
    assign take = req & wb_ack_o;
    assign word_idx = wb_adr_i[7:2];
    assign wr_byte = wb_dat_i[pllc_pkg::DATA_W-1:0];
    assign lane_ok = wb_sel_i[0];
    assign wr_ctl = take & wb_we_i & lane_ok & (word_idx == pllc_pkg::IDX_CTL);
    assign wr_bwc = take & wb_we_i & lane_ok & (word_idx == pllc_pkg::IDX_BWC);
    assign wr_mul_lo = take & wb_we_i & lane_ok & (word_idx == pllc_pkg::IDX_MUL_LO);
    assign wr_mul_hi = take & wb_we_i & lane_ok & (word_idx == pllc_pkg::IDX_MUL_HI);
    assign wr_range = take & wb_we_i & lane_ok & (word_idx == pllc_pkg::IDX_RANGE);
    assign rd_ctl = take & ~wb_we_i & (word_idx == pllc_pkg::IDX_CTL);

    assign range_zero = (range_linear == pllc_pkg::RANGE_ZERO);
    assign mul_all = {mul_hi, mul_lo};

    // break state with clearing disabled shields the flag from control reads, not from a BWC write that clears auto
    assign flag_protect = break_state & ~break_flag_clear_enable; // R17
    // only a flag that the read actually returned is cleared, so a lock
    // change landing between sample and clear is not lost
    assign flag_clear = rd_ctl & flag_seen & ~flag_protect; // R20 R18

    pllc_sync lock_sync_i
    (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(lock_in),
        .sync_out(lock_sync)
    );

    pllc_sync acq_sync_i
    (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(acq_in),
        .sync_out(acq_sync)
    );

    pllc_lock_flag lock_flag_i
    (
        .core_clk(core_clk),
        .rst(rst),
        .lock_sync(lock_sync),
        .auto_mode(auto_mode),
        .clear(flag_clear),
        .flag(flag)
    );

    // registered ack: answer one cycle after the request, drop after one
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req & ~wb_ack_o;
    end

    always_comb
    begin
        rd_byte = '0;
        case (word_idx)
            pllc_pkg::IDX_CTL:
            begin
                rd_byte[pllc_pkg::CTL_IE] = irq_en;
                rd_byte[pllc_pkg::CTL_FLAG] = flag;
                rd_byte[pllc_pkg::CTL_ON] = loop_enable;
                rd_byte[pllc_pkg::CTL_BASE_SEL] = base_sel;
                rd_byte[pllc_pkg::CTL_VPR_HI:pllc_pkg::CTL_VPR_LO] = vpr;
            end
            pllc_pkg::IDX_BWC:
            begin
                rd_byte[pllc_pkg::BWC_AUTO] = auto_mode;
                rd_byte[pllc_pkg::BWC_LOCK] = lock_sync & auto_mode;
                rd_byte[pllc_pkg::BWC_ACQ] = auto_mode ? acq_sync : acq_store;
            end
            pllc_pkg::IDX_MUL_LO:
                rd_byte = mul_lo;
            pllc_pkg::IDX_MUL_HI:
                rd_byte[pllc_pkg::MUL_HI_W-1:0] = mul_hi; // R4
            pllc_pkg::IDX_RANGE:
                rd_byte = range_linear;
            default:
                rd_byte = '0;
        endcase
    end

    // read data is captured as ack rises; unmapped words read zero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wb_dat_o <= '0;
        else if (req & ~wb_ack_o)
            wb_dat_o <= {pllc_pkg::UPPER_ZERO, rd_byte};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            flag_seen <= 1'b0;
        else if (req & ~wb_ack_o)
            flag_seen <= flag;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mul_hi <= pllc_pkg::MUL_HI_RST; // R2
        else if (wr_mul_hi & ~loop_enable) // R3
            mul_hi <= wr_byte[pllc_pkg::MUL_HI_W-1:0]; // R4
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mul_lo <= pllc_pkg::MUL_LO_RST; // R2
        else if (wr_mul_lo & ~loop_enable) // R3
            mul_lo <= wr_byte;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            range_linear <= pllc_pkg::RANGE_RST; // R8
        else if (wr_range & ~loop_enable) // R5
            range_linear <= wr_byte;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            vpr <= pllc_pkg::VPR_RST;
        else if (wr_ctl & ~loop_enable)
            vpr <= wr_byte[pllc_pkg::CTL_VPR_HI:pllc_pkg::CTL_VPR_LO];
    end

    // the loop stays on while the vco drives the base clock
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            loop_enable <= pllc_pkg::LOOP_ON_RST;
        else if (wr_ctl)
            loop_enable <= wr_byte[pllc_pkg::CTL_ON] | base_sel;
    end

    // selecting the vco needs the loop already on: two writes from off.
    // lock is deliberately not checked here
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            base_sel <= 1'b0;
        else if (range_zero | ~loop_enable)
            base_sel <= 1'b0; // R6 R7
        else if (wr_ctl)
            base_sel <= wr_byte[pllc_pkg::CTL_BASE_SEL]; // R13
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq_en <= 1'b0;
        else if (~auto_mode)
            irq_en <= 1'b0; // R11
        else if (wr_ctl)
            irq_en <= wr_byte[pllc_pkg::CTL_IE];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            auto_mode <= 1'b0;
        else if (wr_bwc)
            auto_mode <= wr_byte[pllc_pkg::BWC_AUTO];
    end

    // manual acquisition choice survives a stretch of automatic mode
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            acq_store <= 1'b0;
        else if (wr_bwc & ~auto_mode)
            acq_store <= wr_byte[pllc_pkg::BWC_ACQ];
    end

    // wait mode has no input here: nothing changes on entry to it
    always_comb
    begin
        stop_full = stop_mode & ~osc_run_in_stop;
        next_loop_power = loop_enable & ~range_zero & ~stop_mode; // R6 R14 R16
        next_osc_enable = ~stop_full; // R15 R16
        next_clock_out_enable = ~stop_full; // R15
        next_irq = flag & irq_en & auto_mode & ~stop_full; // R9 R15
        if (mul_all == pllc_pkg::MUL_ZERO)
            next_multiplier_n = pllc_pkg::MUL_ONE; // R1
        else
            next_multiplier_n = mul_all; // R1
    end

    // stop gates power directly; the enable bit itself keeps its value
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            loop_power <= 1'b0;
        else
            loop_power <= next_loop_power;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            osc_enable <= 1'b1;
            clock_out_enable <= 1'b1;
        end
        else
        begin
            osc_enable <= next_osc_enable;
            clock_out_enable <= next_clock_out_enable;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            clockgen_irq_out <= 1'b0;
        else
            clockgen_irq_out <= next_irq;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            multiplier_n <= '0;
        else
            multiplier_n <= next_multiplier_n;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            base_clock_select <= 1'b0;
            power_range <= pllc_pkg::VPR_RST;
            auto_bandwidth <= 1'b0;
            acq_manual <= 1'b0;
        end
        else
        begin
            base_clock_select <= base_sel;
            power_range <= vpr;
            auto_bandwidth <= auto_mode;
            acq_manual <= acq_store;
        end
    end
endmodule

// file: test/pllc_ctrl_checker.sv
`timescale 1ns/100ps
module pllc_ctrl_checker
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic stop_mode,
    input wire logic osc_run_in_stop,
    input wire logic loop_power,
    input wire logic base_clock_select,
    input wire logic [11:0] multiplier_n,
    input wire logic [7:0] range_linear,
    input wire logic auto_bandwidth,
    input wire logic osc_enable,
    input wire logic clock_out_enable,
    input wire logic clockgen_irq_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // multiplier output is only valid from the second edge after reset
    logic up;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            up <= 1'b0;
        else
            up <= 1'b1;
    end
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_high_bits_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i[7:2] == pllc_pkg::IDX_MUL_HI |=> wb_dat_o[7:4] == 4'h0)
        else $error("multiplier high upper bits not zero");
    a_reset_values: assert property (up && !$past(up) |-> multiplier_n == 12'h040
        && range_linear == pllc_pkg::RANGE_RST)
        else $error("wrong reset values");
    a_mult_never_zero: assert property (up |-> multiplier_n != pllc_pkg::MUL_ZERO)
        else $error("multiplier shows zero");
    a_zero_range_off: assert property (range_linear == pllc_pkg::RANGE_ZERO
        && $past(range_linear) == pllc_pkg::RANGE_ZERO |-> !loop_power && !base_clock_select)
        else $error("zero range left loop running");
    a_select_needs_range: assert property (base_clock_select |-> range_linear != pllc_pkg::RANGE_ZERO)
        else $error("base select set with zero range");
    a_regs_frozen_on: assert property (loop_power && $past(loop_power) |->
        $stable(multiplier_n) && $stable(range_linear))
        else $error("programming changed while loop on");
    a_stop_all_low: assert property (stop_mode && !osc_run_in_stop |=>
        !osc_enable && !clock_out_enable && !clockgen_irq_out && !loop_power)
        else $error("outputs active in stop");
    a_stop_osc_kept: assert property (stop_mode && osc_run_in_stop |=> osc_enable && !loop_power)
        else $error("stop with oscillator option wrong");
    a_manual_no_irq: assert property (!auto_bandwidth && !$past(auto_bandwidth) |-> !clockgen_irq_out)
        else $error("interrupt in manual bandwidth mode");
    c_irq_seen: cover property ($rose(clockgen_irq_out));
    c_select_seen: cover property ($rose(base_clock_select));
    c_stop_seen: cover property ($fell(osc_enable));
endmodule
bind pllc_ctrl pllc_ctrl_checker i_chk (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
    .loop_power(loop_power), .base_clock_select(base_clock_select), .multiplier_n(multiplier_n),
    .range_linear(range_linear), .auto_bandwidth(auto_bandwidth), .osc_enable(osc_enable),
    .clock_out_enable(clock_out_enable), .clockgen_irq_out(clockgen_irq_out));

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic lock_in = 1'b0;
    logic stop = 1'b0;
    logic oscs = 1'b0;
    logic brk = 1'b0;
    logic flag_clr_en = 1'b0;
    logic [31:0] rdat;
    logic ack, loop_power, base_sel, auto_bw, acq_m, osc_en, clk_en, irq;
    logic [1:0] prange;
    logic [11:0] mul_n;
    logic [7:0] range_lin;
    logic [7:0] q;
    int n_fail = 0;
    int n_checks = 0;
    always #4 core_clk = ~core_clk;
    pllc_ctrl i_dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .lock_in(lock_in), .acq_in(1'b0), .stop_mode(stop), .osc_run_in_stop(oscs),
        .break_state(brk), .break_flag_clear_enable(flag_clr_en), .loop_power(loop_power),
        .base_clock_select(base_sel), .multiplier_n(mul_n), .range_linear(range_lin), .power_range(prange),
        .auto_bandwidth(auto_bw), .acq_manual(acq_m), .osc_enable(osc_en), .clock_out_enable(clk_en),
        .clockgen_irq_out(irq));
    task check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until ack is sampled high; releasing early would abort the cycle
    task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        req <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do
            @(posedge core_clk);
        while (ack !== 1'b1);
        q = rdat[7:0];
        req <= 1'b0;
        we <= 1'b0;
    endtask
    task wr(input logic [5:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask
    task rd(input logic [5:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        check({4'h0, q}, {4'h0, exp});
    endtask
    task settle;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    // synchroniser needs a few edges before the flag can move
    task toggle_lock;
        @(posedge core_clk);
        lock_in <= ~lock_in;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task give_verdict;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #50000;
        n_fail++;
        give_verdict;
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rd(pllc_pkg::IDX_MUL_LO, 8'h40);
        rd(pllc_pkg::IDX_MUL_HI, 8'h00);
        rd(pllc_pkg::IDX_RANGE, 8'h40);
        check(mul_n, 12'h040);
        wr(pllc_pkg::IDX_MUL_LO, 8'h12);
        wr(pllc_pkg::IDX_RANGE, 8'h11);
        rd(pllc_pkg::IDX_MUL_LO, 8'h40);
        rd(pllc_pkg::IDX_RANGE, 8'h40);
        wr(pllc_pkg::IDX_CTL, 8'h02);
        settle;
        check(12'(prange), 12'h000);
        wr(pllc_pkg::IDX_CTL, 8'h02);
        wr(pllc_pkg::IDX_MUL_HI, 8'hFF);
        rd(pllc_pkg::IDX_MUL_HI, 8'h0F);
        wr(pllc_pkg::IDX_MUL_LO, 8'h00);
        wr(pllc_pkg::IDX_MUL_HI, 8'h00);
        settle;
        check(mul_n, 12'h001);
        check(12'(prange), 12'h002);
        wr(pllc_pkg::IDX_RANGE, 8'h00);
        wr(pllc_pkg::IDX_CTL, 8'h20);
        wr(pllc_pkg::IDX_CTL, 8'h30);
        settle;
        check(12'({loop_power, base_sel}), 12'h000);
        rd(pllc_pkg::IDX_CTL, 8'h20);
        wr(pllc_pkg::IDX_CTL, 8'h00);
        wr(pllc_pkg::IDX_RANGE, 8'h40);
        wr(pllc_pkg::IDX_CTL, 8'h20);
        wr(pllc_pkg::IDX_CTL, 8'h30);
        settle;
        check(12'({loop_power, base_sel}), 12'h003);
        toggle_lock;
        check(12'(irq), 12'h000);
        rd(pllc_pkg::IDX_CTL, 8'h30);
        wr(pllc_pkg::IDX_BWC, 8'hA0);
        wr(pllc_pkg::IDX_CTL, 8'hB0);
        toggle_lock;
        check(12'(irq), 12'h001);
        rd(pllc_pkg::IDX_CTL, 8'hF0);
        rd(pllc_pkg::IDX_CTL, 8'hB0);
        wr(pllc_pkg::IDX_CTL, 8'h30);
        toggle_lock;
        check(12'(irq), 12'h000);
        rd(pllc_pkg::IDX_BWC, 8'hC0);
        rd(pllc_pkg::IDX_CTL, 8'h70);
        brk <= 1'b1;
        toggle_lock;
        rd(pllc_pkg::IDX_CTL, 8'h70);
        wr(pllc_pkg::IDX_CTL, 8'h30);
        rd(pllc_pkg::IDX_CTL, 8'h70);
        flag_clr_en <= 1'b1;
        rd(pllc_pkg::IDX_CTL, 8'h70);
        brk <= 1'b0;
        rd(pllc_pkg::IDX_CTL, 8'h30);
        flag_clr_en <= 1'b0;
        wr(pllc_pkg::IDX_CTL, 8'hB0);
        toggle_lock;
        @(posedge core_clk);
        stop <= 1'b1;
        settle;
        check(12'({osc_en, clk_en, irq, loop_power}), 12'h000);
        @(posedge core_clk);
        oscs <= 1'b1;
        settle;
        check(12'({osc_en, clk_en, irq, loop_power}), 12'h00E);
        @(posedge core_clk);
        stop <= 1'b0;
        settle;
        check(12'({loop_power, base_sel, auto_bw, acq_m, range_lin}), 12'hF40);
        wr(6'h3B, 8'h55);
        rd(6'h3B, 8'h00);
        give_verdict;
    end
endmodule
